// *** hdl/rtcis_slave.sv ***
// Two-wire serial slave port of the real-time clock
//
// What this block does
// - Answer only bus address 1010001b
// - Eighth address bit selects read or write
// - Acknowledge match; otherwise stay released and silent
// - SCL input only; SDA driven low only
// - Ninth clock acknowledges every received byte
// - Acknowledger holds SDA low through clock high
// - No acknowledge ends read; release SDA
// - STOP or new START ends a write
// - First write byte sets pointer, low nibble
// - Pointer increments after each written byte
// - Write: address, pointer, data bytes, STOP
// - Pointer write, restart, read from pointer
// - Pointer advances after each transmitted byte
// - Bare read starts at the stored pointer
// - Timekeeping frozen while an access runs
// - Timeout clears interface 1 s to 2 s
// - Each timeout loses one second
// - After timeout ignore writes, reads give ones
`timescale 1ns/10ps
module rtcis_slave
  import rtcis_pkg::*;
#(
  parameter int TIMEOUT_TICKS = RTCIS_TIMEOUT_TICKS
) (
  // System clock and reset
  input  wire logic                       CLOCK,
  input  wire logic                       SRST,
  // Timeout oscillator
  input  wire logic                       OSC_CLK,
  // Two-wire bus pins
  input  wire logic                       SCL_IN,
  input  wire logic                       SDA_IN,
  output logic                            SDA_OUT,
  output logic                            SDA_OE,
  // Register file access
  output logic [rtcis_pkg::RTCIS_PTR_W-1:0]  REG_ADDR,
  output logic [rtcis_pkg::RTCIS_BYTE_W-1:0] REG_WDATA,
  output logic                            REG_WR,
  input  wire logic [rtcis_pkg::RTCIS_BYTE_W-1:0] REG_RDATA,
  // Timekeeping control
  output logic                            FREEZE,
  output logic                            SECOND_LOST
);

  import rtcis_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                    scl_meta_r;
  logic                    scl_s_r;
  logic                    scl_d_r;
  logic                    sda_meta_r;
  logic                    sda_s_r;
  logic                    sda_d_r;
  logic                    scl_rise;
  logic                    scl_fall;
  logic                    bus_start;
  logic                    bus_stop;

  rtcis_state_e            state_r;
  rtcis_state_e            state_nxt;
  logic [3:0]              cnt_r;
  logic [3:0]              cnt_nxt;
  logic [7:0]              rx_r;
  logic [7:0]              tx_r;
  logic [7:0]              tx_nxt;
  logic                    oe_nxt;
  logic                    first_r;
  logic                    first_nxt;
  logic                    mack_r;
  logic                    addr_hit;
  logic                    load_tx;
  logic                    wr_hit;

  logic [RTCIS_PTR_W-1:0]  ptr_r;
  logic                    active_r;
  logic                    fire_tgl;
  logic                    fire_meta_r;
  logic                    fire_s_r;
  logic                    fire_d_r;
  logic                    timeout;

  // ----------------------------------------------------------------
  // Pin synchronisers and bus condition detection
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      scl_meta_r <= 1'b1;
      scl_s_r    <= 1'b1;
      scl_d_r    <= 1'b1;
      sda_meta_r <= 1'b1;
      sda_s_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end else begin
      scl_meta_r <= SCL_IN;
      scl_s_r    <= scl_meta_r;
      scl_d_r    <= scl_s_r;
      sda_meta_r <= SDA_IN;
      sda_s_r    <= sda_meta_r;
      sda_d_r    <= sda_s_r;
    end
  end

  assign scl_rise  = scl_s_r & ~scl_d_r;
  assign scl_fall  = ~scl_s_r & scl_d_r;
  // Data edges while clock stays high are bus conditions
  assign bus_start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign bus_stop  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

  // ----------------------------------------------------------------
  // Timeout crossing: toggle comes back through two flops
  // ----------------------------------------------------------------
  rtcis_timeout #(
    .TICKS    (TIMEOUT_TICKS)
  ) u_timeout (
    .osc_clk  (OSC_CLK),
    .srst     (SRST),
    .active   (active_r),
    .fire_tgl (fire_tgl)
  );

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      fire_meta_r <= 1'b0;
      fire_s_r    <= 1'b0;
      fire_d_r    <= 1'b0;
    end else begin
      fire_meta_r <= fire_tgl;
      fire_s_r    <= fire_meta_r;
      fire_d_r    <= fire_s_r;
    end
  end

  assign timeout = fire_s_r ^ fire_d_r;

  // ----------------------------------------------------------------
  // Byte decode helpers
  // ----------------------------------------------------------------
  assign addr_hit = (rx_r[7:1] == RTCIS_DEV_ADDR);
  assign wr_hit   = (state_r == RTCIS_WR_BYTE) && scl_fall &&
                    (cnt_r == RTCIS_BITS_BYTE) && !first_r;
  assign load_tx  = scl_fall &&
                    ((state_r == RTCIS_ADDR_ACK && rx_r[0]) ||
                     (state_r == RTCIS_RD_ACK && mack_r));

  // ----------------------------------------------------------------
  // Byte and bit sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    tx_nxt    = tx_r;
    oe_nxt    = SDA_OE;
    first_nxt = first_r;
    if (bus_start) begin
      state_nxt = RTCIS_ADDR;
      cnt_nxt   = RTCIS_CNT_RST;
      oe_nxt    = 1'b0;
    end else if (bus_stop || timeout) begin
      // Interface drops to idle; only a fresh START revives it
      state_nxt = RTCIS_IDLE;
      cnt_nxt   = RTCIS_CNT_RST;
      oe_nxt    = 1'b0;
    end else begin
      case (state_r)
        RTCIS_IDLE: begin
          oe_nxt = 1'b0;
        end
        RTCIS_ADDR, RTCIS_WR_BYTE: begin
          if (scl_rise && cnt_r != RTCIS_BITS_BYTE) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == RTCIS_BITS_BYTE) begin
            cnt_nxt = RTCIS_CNT_RST;
            if (state_r == RTCIS_WR_BYTE) begin
              state_nxt = RTCIS_WR_ACK;
              oe_nxt    = 1'b1;
              first_nxt = 1'b0;
            end else if (addr_hit) begin
              state_nxt = RTCIS_ADDR_ACK;
              oe_nxt    = 1'b1;
            end else begin
              state_nxt = RTCIS_IDLE;
            end
          end
        end
        RTCIS_ADDR_ACK, RTCIS_WR_ACK: begin
          // Low held from the fall before to the fall after
          if (scl_fall) begin
            if (state_r == RTCIS_ADDR_ACK &&
                rx_r[0] == RTCIS_DIR_READ) begin
              state_nxt = RTCIS_RD_BYTE;
              tx_nxt    = {REG_RDATA[6:0], 1'b0};
              oe_nxt    = ~REG_RDATA[7];
              cnt_nxt   = 4'h1;
            end else begin
              state_nxt = RTCIS_WR_BYTE;
              oe_nxt    = 1'b0;
              if (state_r == RTCIS_ADDR_ACK) begin
                first_nxt = 1'b1;
              end
            end
          end
        end
        RTCIS_RD_BYTE: begin
          if (scl_fall) begin
            if (cnt_r == RTCIS_BITS_BYTE) begin
              state_nxt = RTCIS_RD_ACK;
              oe_nxt    = 1'b0;
              cnt_nxt   = RTCIS_CNT_RST;
            end else begin
              oe_nxt  = ~tx_r[7];
              tx_nxt  = {tx_r[6:0], 1'b0};
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        RTCIS_RD_ACK: begin
          if (scl_fall) begin
            if (mack_r) begin
              state_nxt = RTCIS_RD_BYTE;
              tx_nxt    = {REG_RDATA[6:0], 1'b0};
              oe_nxt    = ~REG_RDATA[7];
              cnt_nxt   = 4'h1;
            end else begin
              state_nxt = RTCIS_IDLE;
              oe_nxt    = 1'b0;
            end
          end
        end
        default: begin
          state_nxt = RTCIS_IDLE;
          oe_nxt    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      state_r <= RTCIS_IDLE;
      cnt_r   <= RTCIS_CNT_RST;
      tx_r    <= RTCIS_ALL_ONES;
      SDA_OE  <= 1'b0;
      first_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      tx_r    <= tx_nxt;
      SDA_OE  <= oe_nxt;
      first_r <= first_nxt;
    end
  end

  // Open drain: the line is only ever pulled low
  always_ff @(posedge CLOCK) begin
    SDA_OUT <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Receive shifter and master acknowledge capture
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rx_r <= RTCIS_BYTE_RST;
    end else if (scl_rise && cnt_r != RTCIS_BITS_BYTE &&
                 (state_r == RTCIS_ADDR ||
                  state_r == RTCIS_WR_BYTE)) begin
      rx_r <= {rx_r[6:0], sda_s_r};
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      mack_r <= 1'b0;
    end else if (state_r == RTCIS_RD_ACK && scl_rise) begin
      mack_r <= ~sda_s_r;
    end
  end

  // ----------------------------------------------------------------
  // Register pointer and write strobe
  // ----------------------------------------------------------------
  // Pointer survives between transfers so a bare read continues
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ptr_r <= RTCIS_PTR_RST;
    end else if ((state_r == RTCIS_WR_BYTE) && scl_fall &&
                 (cnt_r == RTCIS_BITS_BYTE) && first_r &&
                 !bus_start && !bus_stop && !timeout) begin
      ptr_r <= rx_r[RTCIS_PTR_W-1:0];
    end else if (REG_WR || (load_tx && !bus_start &&
                 !bus_stop && !timeout)) begin
      ptr_r <= ptr_r + 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      REG_ADDR <= RTCIS_PTR_RST;
    end else begin
      REG_ADDR <= (REG_WR || load_tx) ? ptr_r + 1'b1 : ptr_r;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      REG_WR    <= 1'b0;
      REG_WDATA <= RTCIS_BYTE_RST;
    end else begin
      REG_WR <= wr_hit && !bus_start && !bus_stop &&
                !timeout;
      if (wr_hit) begin
        REG_WDATA <= rx_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Freeze and lost second
  // ----------------------------------------------------------------
  // Raised on an acknowledged address, dropped at STOP or timeout
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      active_r <= 1'b0;
    end else if (bus_stop || timeout) begin
      active_r <= 1'b0;
    end else if (state_r == RTCIS_ADDR && scl_fall &&
                 cnt_r == RTCIS_BITS_BYTE && addr_hit &&
                 !bus_start) begin
      active_r <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      FREEZE      <= 1'b0;
      SECOND_LOST <= 1'b0;
    end else begin
      FREEZE      <= active_r && !timeout;
      SECOND_LOST <= timeout;
    end
  end

endmodule

// *** hdl/rtcis_pkg.sv ***
// Constants and types shared by the RTC two-wire slave port
package rtcis_pkg;

  // ----------------------------------------------------------------
  // Bus address and byte layout
  // ----------------------------------------------------------------
  localparam logic [6:0] RTCIS_DEV_ADDR  = 7'h51;
  localparam logic       RTCIS_DIR_READ  = 1'b1;
  localparam logic       RTCIS_DIR_WRITE = 1'b0;
  localparam int         RTCIS_PTR_W     = 4;
  localparam int         RTCIS_BYTE_W    = 8;
  localparam logic [3:0] RTCIS_BITS_BYTE = 4'h8;
  localparam logic [7:0] RTCIS_ALL_ONES  = 8'hFF;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] RTCIS_PTR_RST   = 4'h0;
  localparam logic [7:0] RTCIS_BYTE_RST  = 8'h00;
  localparam logic [3:0] RTCIS_CNT_RST   = 4'h0;

  // ----------------------------------------------------------------
  // Timeout timing, counted on the 32.768 kHz oscillator
  // ----------------------------------------------------------------
  localparam int RTCIS_OSC_HZ       = 32768;
  // Aimed midway inside the allowed 1 s to 2 s window
  localparam int RTCIS_TIMEOUT_MS   = 1500;
  localparam int RTCIS_TIMEOUT_TICKS =
    (RTCIS_OSC_HZ * RTCIS_TIMEOUT_MS) / 1000;
  localparam int RTCIS_TICK_W       = 17;

  // ----------------------------------------------------------------
  // Byte and bit sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RTCIS_IDLE     = 3'b000,
    RTCIS_ADDR     = 3'b001,
    RTCIS_ADDR_ACK = 3'b010,
    RTCIS_WR_BYTE  = 3'b011,
    RTCIS_WR_ACK   = 3'b100,
    RTCIS_RD_BYTE  = 3'b101,
    RTCIS_RD_ACK   = 3'b110
  } rtcis_state_e;

endpackage

// *** hdl/rtcis_timeout.sv ***
// Bus timeout counter running on the 32.768 kHz oscillator domain
`timescale 1ns/10ps
module rtcis_timeout
  import rtcis_pkg::*;
#(
  parameter int TICKS = RTCIS_TIMEOUT_TICKS
) (
  // Oscillator domain
  input  wire logic osc_clk,
  // Reset from the system domain, resynchronised here
  input  wire logic srst,
  // Access active level from the system domain
  input  wire logic active,
  // Toggles once per expiry
  output logic      fire_tgl
);

  logic                    rst_meta_r;
  logic                    rst_r;
  logic                    act_meta_r;
  logic                    act_r;
  logic [RTCIS_TICK_W-1:0] tick_r;
  logic                    fired_r;

  // ----------------------------------------------------------------
  // Level crossings into the oscillator domain
  // ----------------------------------------------------------------
  always_ff @(posedge osc_clk) begin
    rst_meta_r <= srst;
    rst_r      <= rst_meta_r;
  end

  always_ff @(posedge osc_clk) begin
    if (rst_r) begin
      act_meta_r <= 1'b0;
      act_r      <= 1'b0;
    end else begin
      act_meta_r <= active;
      act_r      <= act_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Count while an access is open; fire once, then wait for release
  // ----------------------------------------------------------------
  always_ff @(posedge osc_clk) begin
    if (rst_r || !act_r) begin
      tick_r  <= '0;
      fired_r <= 1'b0;
    end else if (!fired_r) begin
      if (tick_r == RTCIS_TICK_W'(TICKS - 1)) begin
        fired_r <= 1'b1;
      end
      tick_r <= tick_r + 1'b1;
    end
  end

  always_ff @(posedge osc_clk) begin
    if (rst_r) begin
      fire_tgl <= 1'b0;
    end else if (act_r && !fired_r &&
                 tick_r == RTCIS_TICK_W'(TICKS - 1)) begin
      fire_tgl <= ~fire_tgl;
    end
  end

endmodule

// *** tb/rtcis_monitor.sv ***
// Concurrent checks on the RTC two-wire slave port
`timescale 1ns/10ps
module rtcis_monitor
  import rtcis_pkg::*;
#(
  parameter int TIMEOUT_TICKS = RTCIS_TIMEOUT_TICKS,
  parameter int OSC_NS        = 6,
  parameter int CLK_NS        = 20
) (
  // System side
  input wire logic                   CLOCK,
  input wire logic                   SRST,
  // Bus pins
  input wire logic                   SCL_IN,
  input wire logic                   SDA_IN,
  input wire logic                   SDA_OUT,
  input wire logic                   SDA_OE,
  // Register and timekeeping side
  input wire logic [RTCIS_PTR_W-1:0] REG_ADDR,
  input wire logic                   REG_WR,
  input wire logic                   FREEZE,
  input wire logic                   SECOND_LOST
);
  // Margins cover the two synchronisers on either side of the count
  localparam int LO = TIMEOUT_TICKS * OSC_NS / CLK_NS - 4;
  localparam int HI = (TIMEOUT_TICKS + 8) * OSC_NS / CLK_NS + 12;
  logic [15:0] frz_cnt_r;

  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);

  always_ff @(posedge CLOCK) begin
    if (SRST || !FREEZE)
      frz_cnt_r <= 16'h0000;
    else
      frz_cnt_r <= frz_cnt_r + 16'h0001;
  end

  sda_low_only_a: assert property (
    SDA_OE |-> SDA_OUT == 1'b0)
    else $error("SDA driven other than low");
  oe_scl_low_a: assert property (
    $changed(SDA_OE) |-> !SCL_IN)
    else $error("SDA drive changed while SCL high");
  oe_needs_sel_a: assert property (
    $rose(SDA_OE) |-> ##[0:2] FREEZE)
    else $error("SDA driven without an open access");
  wr_ptr_inc_a: assert property (
    REG_WR |=> REG_ADDR == $past(REG_ADDR) + 4'h1)
    else $error("Pointer not advanced after write");
  wr_in_access_a: assert property (
    REG_WR |-> FREEZE)
    else $error("Write outside an open access");
  lost_once_a: assert property (
    SECOND_LOST |=> (!SECOND_LOST) [*8])
    else $error("Lost second pulse repeated");
  lost_clears_a: assert property (
    SECOND_LOST |-> ##[0:3] (!FREEZE && !SDA_OE))
    else $error("Timeout did not clear the port");
  lost_window_a: assert property (
    SECOND_LOST |-> $past(frz_cnt_r) >= LO)
    else $error("Timeout fired early");
  frz_bound_a: assert property (
    frz_cnt_r <= HI)
    else $error("Access held beyond the timeout");
  stop_ends_a: assert property (
    $rose(SDA_IN) && SCL_IN && $past(SCL_IN) |-> ##[1:8] !FREEZE)
    else $error("STOP did not end the access");
endmodule

bind rtcis_slave rtcis_monitor #(.TIMEOUT_TICKS(TIMEOUT_TICKS)) u_mon (
  .CLOCK(CLOCK), .SRST(SRST), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .REG_ADDR(REG_ADDR),
  .REG_WR(REG_WR), .FREEZE(FREEZE), .SECOND_LOST(SECOND_LOST)
);

// *** tb/rtcis_master.sv ***
// Behavioural two-wire bus master facing the slave port
`timescale 1ns/10ps
module rtcis_master (
  // Timing reference
  input  wire logic clk,
  // Resolved data line
  input  wire logic sda,
  // Master lines, high means released
  output logic      scl,
  output logic      sda_m
);
  // ----------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------
  // Half-phase in clock cycles; raised by the bench to act slowly
  int hp = 10;

  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  task automatic hw();
    repeat (hp) @(posedge clk);
    #1;
  endtask

  // Data changes only while SCL is low
  task automatic bit1(input logic b, output logic r);
    sda_m = b;
    hw();
    scl = 1'b1;
    hw();
    r = sda;
    scl = 1'b0;
    hw();
  endtask

  // Byte MSB first, then the acknowledge slot
  task automatic xb(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      bit1(tx[i], rx[i]);
    end
  endtask

  task automatic start();
    sda_m = 1'b1;
    hw();
    scl = 1'b1;
    hw();
    sda_m = 1'b0;
    hw();
    scl = 1'b0;
    hw();
  endtask

  task automatic stop();
    sda_m = 1'b0;
    hw();
    scl = 1'b1;
    hw();
    sda_m = 1'b1;
    hw();
  endtask
endmodule

// *** tb/rtcis_slave_tb.sv ***
// Self-checking bench for the RTC two-wire slave port
`timescale 1ns/10ps
module rtcis_slave_tb;
  import rtcis_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic       clock = 1'b0;
  logic       srst  = 1'b1;
  logic       osc   = 1'b0;
  logic       scl;
  logic       sda_m;
  logic       sda;
  logic       sda_out;
  logic       sda_oe;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       reg_wr;
  logic       freeze;
  logic       lost_p;
  logic [7:0] regs [16];
  logic [8:0] rx;
  int         num_errors = 0;
  int         num_checks = 0;
  int         cyc = 0;
  int         lost = 0;

  initial begin
    forever #10 clock = ~clock;
  end
  initial begin
    #1.3;
    forever #3 osc = ~osc;
  end

  // Open-drain line with pull-up
  assign sda = sda_m & ~(sda_oe & ~sda_out);
  assign reg_rdata = regs[reg_addr];

  always @(posedge clock) begin
    if (reg_wr === 1'b1)
      regs[reg_addr] <= reg_wdata;
    if (lost_p === 1'b1)
      lost++;
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      print_verdict();
    end
  end

  rtcis_slave #(.TIMEOUT_TICKS(20000)) dut (
    .CLOCK(clock), .SRST(srst), .OSC_CLK(osc), .SCL_IN(scl),
    .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RDATA(reg_rdata), .FREEZE(freeze), .SECOND_LOST(lost_p)
  );
  rtcis_master u_master (.clk(clock), .sda(sda), .scl(scl),
    .sda_m(sda_m));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_write();
    logic r;
    u_master.start();
    repeat (3) u_master.bit1(1'b0, r);
    u_master.start();
    u_master.xb({8'hA2, 1'b1}, rx);
    check(16'(rx[0]), 16'h0000);
    check(16'(freeze), 16'h0001);
    u_master.xb({8'hF5, 1'b1}, rx);
    check(16'(rx[0]), 16'h0000);
    u_master.xb({8'h3C, 1'b1}, rx);
    check(16'(rx[0]), 16'h0000);
    u_master.xb({8'h7E, 1'b1}, rx);
    check(16'(rx[0]), 16'h0000);
    u_master.stop();
    check(16'(regs[5]), 16'h003C);
    check(16'(regs[6]), 16'h007E);
    check(16'(freeze), 16'h0000);
    $display("t_write done");
  endtask

  task automatic t_read();
    u_master.hp = 25;
    u_master.start();
    u_master.xb({8'hA2, 1'b1}, rx);
    u_master.xb({8'h15, 1'b1}, rx);
    u_master.start();
    u_master.xb({8'hA3, 1'b1}, rx);
    check(16'(rx[0]), 16'h0000);
    u_master.xb({8'hFF, 1'b0}, rx);
    check(16'(rx[8:1]), 16'h003C);
    u_master.xb({8'hFF, 1'b1}, rx);
    check(16'(rx), 16'h00FD);
    check(16'(sda_oe), 16'h0000);
    u_master.stop();
    u_master.hp = 10;
    $display("t_read done");
  endtask

  task automatic t_bare();
    u_master.start();
    u_master.xb({8'hA3, 1'b1}, rx);
    check(16'(rx[0]), 16'h0000);
    u_master.xb({8'hFF, 1'b1}, rx);
    check(16'(rx[8:1]), 16'h0077);
    u_master.stop();
    $display("t_bare done");
  endtask

  task automatic t_wrong();
    logic [7:0] bad [3];
    bad = '{8'hA0, 8'h8B, 8'hE2};
    foreach (bad[i]) begin
      u_master.start();
      u_master.xb({bad[i], 1'b1}, rx);
      check(16'(rx[0]), 16'h0001);
      check(16'(freeze), 16'h0000);
      u_master.stop();
    end
    $display("t_wrong done");
  endtask

  task automatic t_timeout();
    u_master.start();
    u_master.xb({8'hA2, 1'b1}, rx);
    for (int i = 0; i < 8000 && lost == 0; i++)
      @(posedge clock);
    repeat (5) @(posedge clock);
    #1;
    check(16'(lost), 16'h0001);
    check(16'(freeze), 16'h0000);
    u_master.xb({8'h00, 1'b1}, rx);
    check(16'(rx), 16'h0001);
    u_master.xb(9'h1FF, rx);
    check(16'(rx), 16'h01FF);
    u_master.stop();
    // A write that slipped through would have put FFh at register 0
    check(16'(regs[0]), 16'h0000);
    u_master.start();
    u_master.xb({8'hA2, 1'b1}, rx);
    check(16'(rx[0]), 16'h0000);
    u_master.stop();
    check(16'(lost), 16'h0001);
    $display("t_timeout done");
  endtask

  initial begin
    for (int i = 0; i < 16; i++)
      regs[i] = 8'(i * 8'h11);
    repeat (20) @(posedge clock);
    #1;
    srst = 1'b0;
    repeat (5) @(posedge clock);
    #1;
    t_write();
    t_read();
    t_bare();
    t_wrong();
    t_timeout();
    print_verdict();
  end
endmodule
